// ### verilog/msg_port_pkg.sv
// Shared constants for the message-based slave port and its commander
// Function
// - Commander polls until write-ready and output-ready
// - Commander requests byte by writing deff
// - Commander polls until read-ready before collecting
// - Data-low read returns the requested output byte
// - Commander polls until write-ready and input-ready
// - Byte-available words bc/bd carry byte, both decoded
// - Response register holds the four handshake flags
// - Device answers only inside its 64-byte window, or to interrupt acknowledge while a request is pending
// - Window base is address times 40 plus c000
// - Only standard registers and interrupt acknowledge exist
// - Other modules avoid undefined window locations
// - Identity and type words are fixed read-only
// - Offset 4 reads status, writes control
// - Offset 6 is written and retained
// - Capability word always reads b7ff
// - Response register shows live handshake state
// - Protocol events raise a bus interrupt request
// - Interrupt level is programmable
package msg_port_pkg;

    // ********************************************************************
    // Device window
    // ********************************************************************
    localparam logic [5:0]  OFS_IDENT    = 6'h00;
    localparam logic [5:0]  OFS_TYPE     = 6'h02;
    localparam logic [5:0]  OFS_STATUS   = 6'h04;
    localparam logic [5:0]  OFS_OFFSET   = 6'h06;
    localparam logic [5:0]  OFS_PROTO    = 6'h08;
    localparam logic [5:0]  OFS_RESP     = 6'h0a;
    localparam logic [5:0]  OFS_DHIGH    = 6'h0c;
    localparam logic [5:0]  OFS_DLOW     = 6'h0e;
    localparam logic [15:0] A16_BASE     = 16'hc000;
    localparam logic [15:0] PROTO_WORD   = 16'hb7ff;
    localparam logic [15:0] CMD_BYTE_REQ = 16'hdeff;
    localparam logic [7:0]  BAV_NOEND    = 8'hbc;
    localparam logic [7:0]  BAV_END      = 8'hbd;
    localparam int          RSP_WR       = 9;
    localparam int          RSP_RR       = 10;
    localparam int          RSP_DIR      = 12;
    localparam int          RSP_DOR      = 13;
    localparam int          CTL_RESET    = 0;
    localparam int          CTL_LVL_LSB  = 4;
    localparam int          STS_READY    = 2;
    localparam int          STS_PASSED   = 3;
    localparam logic [2:0]  LVL_RESET    = 3'h1;

    // ********************************************************************
    // Commander APB map
    // ********************************************************************
    localparam logic [7:0]  REG_CMD      = 8'h00;
    localparam logic [7:0]  REG_STAT     = 8'h04;
    localparam logic [7:0]  REG_DATA     = 8'h08;
    localparam logic [7:0]  REG_TARGET   = 8'h0c;
    localparam logic [7:0]  REG_IRQ_ST   = 8'h10;
    localparam logic [7:0]  REG_IRQ_MASK = 8'h14;
    localparam logic [7:0]  REG_IACK_ID  = 8'h18;
    localparam int          CMD_RD       = 0;
    localparam int          CMD_WR       = 1;
    localparam int          CMD_END      = 2;
    localparam int          CMD_BYTE_LSB = 8;
    localparam int          EV_RD        = 0;
    localparam int          EV_WR        = 1;
    localparam int          EV_IRQ       = 2;

    // Base of the 64-byte window for a logical address
    function automatic logic [15:0] la_base(input logic [7:0] la);
        return A16_BASE + {2'b00, la, 6'h00};
    endfunction : la_base

endpackage : msg_port_pkg

// ### verilog/msg_link_if.sv
// Backplane link between commander and message-based device
interface msg_link_if;
    logic        strobe;    // Cycle request, held until ack
    logic        write;
    logic        iack;      // Interrupt acknowledge cycle
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        ack;       // One-cycle answer
    logic [15:0] rdata;
    logic [2:0]  irq_level; // Zero means no request

    modport device (
        input  strobe, write, iack, addr, wdata,
        output ack, rdata, irq_level
    );
    modport commander (
        input  ack, rdata, irq_level,
        output strobe, write, iack, addr, wdata
    );
endinterface : msg_link_if

// ### verilog/msg_device_end.sv
// Message-based device end: configuration registers and word-serial handshake
module msg_device_end
    import msg_port_pkg::*;
#(
    parameter logic [15:0] IDENT_WORD = 16'h0f01, // Arbitrary value
    parameter logic [15:0] TYPE_WORD  = 16'h0a02  // Arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       rst,
    msg_link_if.device      link,
    input  wire logic [7:0] la_pins,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_end,
    output logic            rx_valid,
    input  wire logic       rx_ready
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    logic [7:0]  la_meta;
    logic [7:0]  la_sync;
    logic [5:0]  ofs;
    logic        in_win;
    logic        hit;
    logic        reg_wr;
    logic        reg_rd;
    logic        dlow_wr;
    logic        byte_req;
    logic        byte_av;
    logic        dlow_rd;
    logic        iack_hit;
    logic        output_byte_ready;
    logic        rr;
    logic        dir;
    logic        wr_busy;
    logic        ctl_reset;
    logic [2:0]  lvl;
    logic [15:0] offset_word;
    logic [7:0]  out_byte;
    logic        irq_pend;
    logic [15:0] resp_word;
    logic [15:0] status_word;
    logic [15:0] rd_word;

    // ********************************************************************
    // Logical address straps
    // ********************************************************************

    // Switches are asynchronous; two flops before the window decode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            la_meta <= 8'h00;
            la_sync <= 8'h00;
        end else begin
            la_meta <= la_pins;
            la_sync <= la_meta;
        end
    end

    // ********************************************************************
    // Cycle decode
    // ********************************************************************

    // Byte lane bit ignored: every register is a 16-bit word
    assign ofs    = {link.addr[5:1], 1'b0};
    assign in_win = link.addr[15:6] == 10'(la_base(la_sync) >> 6);
    // Acknowledge only owed while a request is pending
    assign iack_hit = link.strobe && !link.ack && link.iack && irq_pend;
    assign hit      = link.strobe && !link.ack && (link.iack ? irq_pend : in_win);
    assign reg_wr   = hit && !link.iack && link.write;
    assign reg_rd   = hit && !link.iack && !link.write;
    assign dlow_wr  = reg_wr && ofs == OFS_DLOW;
    assign dlow_rd  = reg_rd && ofs == OFS_DLOW;

    // Output path is ready only with a byte waiting and none unread
    assign output_byte_ready = tx_valid && !rr && !ctl_reset;
    // Commands arriving without their ready flag are dropped
    assign byte_req = dlow_wr && link.wdata == CMD_BYTE_REQ && output_byte_ready;
    assign byte_av  = dlow_wr && dir &&
                      (link.wdata[15:8] == BAV_NOEND || link.wdata[15:8] == BAV_END);

    // ********************************************************************
    // Read data
    // ********************************************************************

    // Live handshake flags, others read zero
    always_comb begin
        resp_word          = 16'h0000;
        resp_word[RSP_WR]  = !wr_busy;
        resp_word[RSP_RR]  = rr;
        resp_word[RSP_DIR] = dir;
        resp_word[RSP_DOR] = output_byte_ready;
    end

    // Status mirrors the soft reset and readiness of the interface
    always_comb begin
        status_word             = 16'h0000;
        status_word[CTL_RESET]  = ctl_reset;
        status_word[STS_READY]  = !ctl_reset;
        status_word[STS_PASSED] = 1'b1;
        status_word[CTL_LVL_LSB +: 3] = lvl;
    end

    // Offset and data-high are not readable; holes read zero
    always_comb begin
        case (ofs)
            OFS_IDENT:  rd_word = IDENT_WORD;
            OFS_TYPE:   rd_word = TYPE_WORD;
            OFS_STATUS: rd_word = status_word;
            OFS_PROTO:  rd_word = PROTO_WORD;
            OFS_RESP:   rd_word = resp_word;
            OFS_DLOW:   rd_word = {8'h00, out_byte};
            default:    rd_word = 16'h0000;
        endcase
    end

    // ********************************************************************
    // Bus answer
    // ********************************************************************

    // Registered answer one cycle after the strobe is seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.ack   <= 1'b0;
            link.rdata <= 16'h0000;
        end else begin
            link.ack <= hit;
            if (iack_hit) begin
                link.rdata <= {8'h00, la_sync};
            end else if (reg_rd) begin
                link.rdata <= rd_word;
            end
        end
    end

    // ********************************************************************
    // Configuration registers
    // ********************************************************************

    // Control bits: soft reset and interrupt level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_reset <= 1'b0;
            lvl       <= LVL_RESET;
        end else if (reg_wr && ofs == OFS_STATUS) begin
            ctl_reset <= link.wdata[CTL_RESET];
            lvl       <= link.wdata[CTL_LVL_LSB +: 3];
        end
    end

    // Window offset kept as written; nothing reads it back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            offset_word <= 16'h0000;
        end else if (reg_wr && ofs == OFS_OFFSET) begin
            offset_word <= link.wdata;
        end
    end

    // ********************************************************************
    // Output path
    // ********************************************************************

    // Byte request latches the user byte and raises read-ready
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rr       <= 1'b0;
            out_byte <= 8'h00;
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= byte_req;
            if (byte_req) begin
                out_byte <= tx_data;
            end
            if (ctl_reset) begin
                rr <= 1'b0;
            end else if (byte_req) begin
                rr <= 1'b1;
            end else if (dlow_rd) begin
                rr <= 1'b0;
            end
        end
    end

    // ********************************************************************
    // Input path
    // ********************************************************************

    // Input-ready drops on each accepted byte until the user frees it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir      <= 1'b0;
            rx_valid <= 1'b0;
            rx_data  <= 8'h00;
            rx_end   <= 1'b0;
        end else begin
            rx_valid <= byte_av;
            if (byte_av) begin
                rx_data <= link.wdata[7:0];
                rx_end  <= link.wdata[8];
            end
            if (ctl_reset || byte_av) begin
                dir <= 1'b0;
            end else if (rx_ready) begin
                dir <= 1'b1;
            end
        end
    end

    // Write-ready blinks low for the cycle after a data-low write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_busy <= 1'b0;
        end else begin
            wr_busy <= dlow_wr;
        end
    end

    // ********************************************************************
    // Interrupt request
    // ********************************************************************

    // A new byte ready is the protocol event; new event beats acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_pend       <= 1'b0;
            link.irq_level <= 3'h0;
        end else begin
            if (byte_req) begin
                irq_pend <= 1'b1;
            end else if (iack_hit) begin
                irq_pend <= 1'b0;
            end
            // Level zero in control silences the request
            link.irq_level <= irq_pend ? lvl : 3'h0;
        end
    end

endmodule : msg_device_end

// ### verilog/msg_commander_end.sv
// Commander end: APB-controlled word-serial master with interrupt handling
module msg_commander_end
    import msg_port_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    msg_link_if.commander    link
);

    typedef enum logic [2:0] {
        IDLE, RD_POLL, RD_REQ, RD_POLL_RR, RD_FETCH, WR_POLL, WR_SEND, IACK_CYC
    } cmd_state_e;

    cmd_state_e  state;
    logic [7:0]  target_la;
    logic [7:0]  tx_byte;
    logic        tx_end;
    logic [7:0]  rx_byte;
    logic [7:0]  iack_id;
    logic [2:0]  irq_st;
    logic [2:0]  irq_mask;
    logic [2:0]  ev;
    logic        acc;
    logic        setup;
    logic        mapped;
    logic        wr_cmd;
    logic [5:0]  req_ofs;
    logic        req_write;
    logic [15:0] req_wdata;
    logic [31:0] rd_mux;

    // ********************************************************************
    // APB slave
    // ********************************************************************

    // Writes land on the edge that samples pready high
    assign setup  = psel && penable && !pready;
    assign acc    = psel && penable && pready;
    assign wr_cmd = acc && pwrite && paddr == REG_CMD && state == IDLE;
    assign mapped = paddr == REG_CMD || paddr == REG_STAT || paddr == REG_DATA ||
                    paddr == REG_TARGET || paddr == REG_IRQ_ST ||
                    paddr == REG_IRQ_MASK || paddr == REG_IACK_ID;

    // Read mux, unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            REG_STAT:     rd_mux = {31'h0000_0000, state != IDLE};
            REG_DATA:     rd_mux = {24'h00_0000, rx_byte};
            REG_TARGET:   rd_mux = {24'h00_0000, target_la};
            REG_IRQ_ST:   rd_mux = {29'h0000_0000, irq_st};
            REG_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask};
            REG_IACK_ID:  rd_mux = {24'h00_0000, iack_id};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // Fixed one wait state keeps the answer registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Software-owned settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            target_la <= 8'h00;
            irq_mask  <= 3'h0;
        end else if (acc && pwrite) begin
            if (paddr == REG_TARGET) begin
                target_la <= pwdata[7:0];
            end
            if (paddr == REG_IRQ_MASK) begin
                irq_mask <= pwdata[2:0];
            end
        end
    end

    // ********************************************************************
    // Interrupts
    // ********************************************************************
    assign ev[EV_RD]  = state == RD_FETCH && link.ack;
    assign ev[EV_WR]  = state == WR_SEND && link.ack;
    assign ev[EV_IRQ] = state == IACK_CYC && link.ack;

    // Set beats a same-cycle write-one-to-clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_st <= 3'h0;
            irq    <= 1'b0;
        end else begin
            irq_st <= (irq_st & ~((acc && pwrite && paddr == REG_IRQ_ST) ? pwdata[2:0] : 3'h0)) | ev;
            irq    <= |(irq_st & irq_mask);
        end
    end

    // ********************************************************************
    // Word-serial sequencer
    // ********************************************************************

    // Link cycle that each state issues
    always_comb begin
        req_ofs   = OFS_RESP;
        req_write = 1'b0;
        req_wdata = 16'h0000;
        unique case (state)
            IDLE, RD_POLL, RD_POLL_RR, WR_POLL, IACK_CYC: begin
                req_ofs = OFS_RESP;
            end
            RD_REQ: begin
                req_ofs   = OFS_DLOW;
                req_write = 1'b1;
                req_wdata = CMD_BYTE_REQ;
            end
            RD_FETCH: begin
                req_ofs = OFS_DLOW;
            end
            WR_SEND: begin
                req_ofs   = OFS_DLOW;
                req_write = 1'b1;
                req_wdata = {tx_end ? BAV_END : BAV_NOEND, tx_byte};
            end
        endcase
    end

    // Strobe held until the one-cycle ack, then the flags decide
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= IDLE;
            link.strobe <= 1'b0;
            link.write  <= 1'b0;
            link.iack   <= 1'b0;
            link.addr   <= 16'h0000;
            link.wdata  <= 16'h0000;
            tx_byte     <= 8'h00;
            tx_end      <= 1'b0;
            rx_byte     <= 8'h00;
            iack_id     <= 8'h00;
        end else if (state == IDLE) begin
            if (link.irq_level != 3'h0) begin
                state <= IACK_CYC;
            end else if (wr_cmd && pwdata[CMD_RD]) begin
                state <= RD_POLL;
            end else if (wr_cmd && pwdata[CMD_WR]) begin
                state   <= WR_POLL;
                tx_byte <= pwdata[CMD_BYTE_LSB +: 8];
                tx_end  <= pwdata[CMD_END];
            end
        end else if (!link.strobe) begin
            link.strobe <= 1'b1;
            link.iack   <= state == IACK_CYC;
            link.write  <= req_write;
            link.addr   <= la_base(target_la) + {10'h000, req_ofs};
            link.wdata  <= req_wdata;
        end else if (link.ack) begin
            link.strobe <= 1'b0;
            unique case (state)
                RD_POLL: begin
                    if (link.rdata[RSP_WR] && link.rdata[RSP_DOR]) begin
                        state <= RD_REQ;
                    end
                end
                RD_REQ: begin
                    state <= RD_POLL_RR;
                end
                RD_POLL_RR: begin
                    if (link.rdata[RSP_RR]) begin
                        state <= RD_FETCH;
                    end
                end
                RD_FETCH: begin
                    rx_byte <= link.rdata[7:0];
                    state   <= IDLE;
                end
                WR_POLL: begin
                    if (link.rdata[RSP_WR] && link.rdata[RSP_DIR]) begin
                        state <= WR_SEND;
                    end
                end
                WR_SEND, IACK_CYC: begin
                    if (state == IACK_CYC) begin
                        iack_id <= link.rdata[7:0];
                    end
                    state <= IDLE;
                end
                IDLE: begin
                    state <= IDLE;
                end
            endcase
        end
    end

endmodule : msg_commander_end

// ### verification/msg_port_chk.sv
// Checker on the link between commander and device
module msg_port_chk
    import msg_port_pkg::*;
#(
    parameter logic [7:0] LA = 8'h00
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        strobe,
    input wire logic        write,
    input wire logic        iack,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        ack,
    input wire logic [15:0] rdata,
    input wire logic [2:0]  irq_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] base;
    logic        take;
    logic        in_win;
    logic        rd;
    // Window base worked out by hand, not through the design's helper
    assign base   = 16'hc000 + {2'b00, LA, 6'h00};
    assign take   = strobe && !ack;
    assign in_win = addr[15:6] == base[15:6];
    assign rd     = take && !write && !iack && in_win;
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_win_ack; take && !iack && in_win |=> ack; endproperty
    a_win_ack: assert property (p_win_ack) else $error("window access not answered");
    property p_win_refuse; take && !iack && !in_win |=> !ack; endproperty
    a_win_refuse: assert property (p_win_refuse) else $error("foreign address answered");
    property p_iack_id; take && iack && irq_level != 3'h0 |=> ack && rdata[7:0] == LA; endproperty
    a_iack_id: assert property (p_iack_id) else $error("bad interrupt answer");
    property p_resp_bits; rd && addr[5:1] == OFS_RESP[5:1] |=> (rdata & 16'hc9ff) == 16'h0000; endproperty
    a_resp_bits: assert property (p_resp_bits) else $error("stray response bits");
    property p_dlow_read; rd && addr[5:1] == OFS_DLOW[5:1] |=> rdata[15:8] == 8'h00; endproperty
    a_dlow_read: assert property (p_dlow_read) else $error("data-low upper byte set");
    property p_req_irq; take && write && in_win && wdata == CMD_BYTE_REQ |-> ##2 irq_level == LVL_RESET; endproperty
    a_req_irq: assert property (p_req_irq) else $error("byte request raised no interrupt");
    property p_iack_clear; take && iack && irq_level != 3'h0 |-> ##[1:3] irq_level == 3'h0; endproperty
    a_iack_clear: assert property (p_iack_clear) else $error("interrupt not withdrawn");
    property p_rdata_hold; !ack |-> $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without answer");
    c_iack: cover property (take && iack);
    c_end_byte: cover property (take && write && wdata[15:8] == BAV_END);
    c_refused: cover property (take && !iack && !in_win);
endmodule : msg_port_chk

// ### verification/tb_message_based_bus_slave_port.sv
// Bench joining commander and device ends over the link
module tb_message_based_bus_slave_port
    import msg_port_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] LA = 8'h2a;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0]  paddr, tx_data, rx_data, got_byte;
    logic [31:0] pwdata, prdata, q, seed, b;
    logic        tx_valid, tx_ready, rx_end, rx_valid, rx_ready, got_end;
    int          n_errors, total_checks, cycles;
    msg_link_if link_if();
    msg_commander_end i_msg_commander_end (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .link(link_if));
    msg_device_end i_msg_device_end (.clk(clk), .rst(rst), .link(link_if), .la_pins(LA), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_end(rx_end), .rx_valid(rx_valid),
        .rx_ready(rx_ready));
    msg_port_chk #(.LA(LA)) i_msg_port_chk (.clk(clk), .rst(rst), .strobe(link_if.strobe),
        .write(link_if.write), .iack(link_if.iack), .addr(link_if.addr), .wdata(link_if.wdata),
        .ack(link_if.ack), .rdata(link_if.rdata), .irq_level(link_if.irq_level));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // User side of the device: capture bytes, stall reception now and then, cut a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        rx_ready <= cycles[2] ^ cycles[0];
        if (rx_valid) begin
            got_byte <= rx_data;
            got_end <= rx_end;
        end
        if (tx_ready) tx_valid <= 1'b0;
        if (cycles == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] cmd_word(input logic [7:0] d, input logic fin, input logic rdn);
        return {16'h0, d, 5'h0, fin, !rdn, rdn};
    endfunction : cmd_word
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
        end
    endtask : check
    // APB transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wait_ev(input int n);
        int k;
        k = 0;
        do begin
            apb(1'b0, REG_IRQ_ST, 32'h0);
            k++;
        end while (q[n] !== 1'b1 && k < 200);
    endtask : wait_ev
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        seed = 32'hb0e0b6a4;
        {rst, psel, penable, pwrite, paddr, pwdata, tx_data, tx_valid, rx_ready} = '0;
        rst = 1'b1;
        {n_errors, total_checks, cycles} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b1, REG_TARGET, {24'h0, LA});
        apb(1'b0, REG_TARGET, 32'h0);
        check(q, {24'h0, LA}, "target");
        // Byte reads, interrupt masked or unmasked at random
        for (int i = 0; i < 4; i++) begin
            b = rnd();
            apb(1'b1, REG_IRQ_MASK, {31'h0, b[9]});
            tx_data <= b[7:0];
            tx_valid <= 1'b1;
            apb(1'b1, REG_CMD, cmd_word(8'h00, 1'b0, 1'b1));
            wait_ev(EV_IRQ);
            check(q[2:0], 3'b101, "read events");
            check(irq, b[9], "irq line");
            apb(1'b0, REG_DATA, 32'h0);
            check(q, {24'h0, b[7:0]}, "read byte");
            apb(1'b0, REG_IACK_ID, 32'h0);
            check(q[7:0], LA, "iack id");
            apb(1'b1, REG_IRQ_ST, 32'h7);
            @(posedge clk); // Line follows status one edge late
            check(irq, 1'b0, "irq cleared");
        end
        $display("read test done");
        // Byte writes with and without End, edge bytes first
        for (int i = 0; i < 6; i++) begin
            b = (i == 0) ? 32'h0 : (i == 1) ? 32'h1ff : rnd();
            apb(1'b1, REG_CMD, cmd_word(b[7:0], b[8], 1'b0));
            wait_ev(EV_WR);
            check(got_byte, b[7:0], "sent byte");
            check(got_end, b[8], "end flag");
            apb(1'b1, REG_IRQ_ST, 32'h7);
        end
        $display("write test done");
        apb(1'b0, 8'h1c, 32'h0);
        check(e, 1'b1, "unmapped");
        $display("unmapped test done");
        // Foreign target is never answered; reset in mid-run recovers
        apb(1'b1, REG_TARGET, {24'h0, LA + 8'h01});
        apb(1'b1, REG_CMD, cmd_word(8'h00, 1'b0, 1'b1));
        repeat (40) @(posedge clk);
        apb(1'b0, REG_STAT, 32'h0);
        check(q[0], 1'b1, "hung busy");
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, REG_STAT, 32'h0);
        check(q[0], 1'b0, "idle after reset");
        $display("refusal test done");
        tally_and_finish();
    end
endmodule : tb_message_based_bus_slave_port
